// ---- include/lrocfg_pkg.sv ----
/*
 * Constants for the per-channel range, overcurrent threshold and
 * regulation mode configuration of the dual laser driver.
 * Assumes an 8-bit register space written by the serial front end.
 */
package lrocfg_pkg;

   // =========================================================
   // sizes
   // =========================================================
   localparam int NUM_CH = 2;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int FS_W = 16;
   localparam int STEP_W = 12;

   // =========================================================
   // register offsets, one entry per channel where split
   // =========================================================
   localparam logic [ADDR_W-1:0] MODE_ADDR [NUM_CH] = '{8'h10, 8'h15};
   localparam logic [ADDR_W-1:0] THR_ADDR [NUM_CH] = '{8'h11, 8'h16};
   localparam logic [ADDR_W-1:0] RSEL_ADDR = 8'h1A;
   localparam logic [ADDR_W-1:0] SIM_ADDR = 8'h1D;
   localparam logic [ADDR_W-1:0] CRNG_ADDR = 8'h1E;

   // =========================================================
   // field positions
   // =========================================================
   localparam int MODE_BIT = 0;
   localparam int RSEL_BIT [NUM_CH] = '{0, 4};
   localparam int SIM_BIT [NUM_CH] = '{5, 6};
   localparam int CRNG_LSB [NUM_CH] = '{0, 4};
   localparam int CRNG_W = 2;

   // =========================================================
   // reset values and codes
   // =========================================================
   localparam logic [DATA_W-1:0] THR_RESET = 8'hFF;
   localparam logic [DATA_W-1:0] THR_OFF_CODE = 8'h00;
   localparam logic [CRNG_W-1:0] CRNG_RESET = 2'h0;
   localparam logic MODE_POWER = 1'b0;   // power regulation
   localparam logic MODE_CURRENT = 1'b1; // current regulation
   localparam logic RSEL_HIGH = 1'b0;    // high current range

   // =========================================================
   // full scale in 0.1 mA units, indexed by range code
   // factors 1, 0.13, 0.03, 0.012 of the 750 mA or 90 mA scale
   // =========================================================
   localparam logic [FS_W-1:0] FS_HIGH [4] =
      '{16'h1D4C, 16'h03E8, 16'h00FA, 16'h005A}; // 750,100,25,9 mA
   localparam logic [FS_W-1:0] FS_LOW [4] =
      '{16'h0384, 16'h0078, 16'h001E, 16'h000B}; // 90,12,3,1.1 mA

   // threshold step in uA: 3 mA high range, 0.375 mA low range
   localparam logic [STEP_W-1:0] STEP_HIGH_UA = 12'hBB8;
   localparam logic [STEP_W-1:0] STEP_LOW_UA = 12'h177;

endpackage : lrocfg_pkg

// ---- src/lrocfg_top.sv ----
/*
 * Per-channel range, overcurrent threshold, fault simulation and
 * regulation mode registers of the dual laser driver, plus the
 * overcurrent error flags, channel disable and check output.
 * Assumes a serial front end on i_clk that presents byte writes and
 * reads, and analog comparators whose outputs are asynchronous.
 */
`timescale 1ns/1ps

// Notes on behaviour
// - channel one range code sets factor
// - range resistor bit picks full-scale table
// - channel two range at bits 5:4
// - channel one threshold at 0x11, reset FF
// - code 00 disables protection in current mode
// - channel two threshold at 0x16, reset FF
// - simulation sets flag, check, disables channel
// - simulated error held while bit set
// - simulation bits 5 and 6 at 0x1D
// - channel one mode bit at 0x10
// - channel two mode bit at 0x15
// - range resistor bits 0 and 4 at 0x1A
// - step 0.375 mA low, 3 mA high
// - linear reference disables overcurrent protection
module lrocfg_top (
   input wire logic i_clk,
   input wire logic i_rstn,
   input wire logic [lrocfg_pkg::ADDR_W-1:0] i_reg_addr,
   input wire logic [lrocfg_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic [lrocfg_pkg::NUM_CH-1:0] i_overcurrent_detect,
   input wire logic [lrocfg_pkg::NUM_CH-1:0] i_reference_linear_select,
   input wire logic [lrocfg_pkg::NUM_CH-1:0] i_error_clear,
   input wire logic i_other_error,
   output logic [lrocfg_pkg::DATA_W-1:0] o_reg_rdata,
   output logic [lrocfg_pkg::NUM_CH-1:0] o_regulation_mode,
   output logic [lrocfg_pkg::NUM_CH-1:0] o_range_resistor_select,
   output logic [lrocfg_pkg::NUM_CH*lrocfg_pkg::CRNG_W-1:0]
      o_current_range_factor,
   output logic [lrocfg_pkg::NUM_CH*lrocfg_pkg::DATA_W-1:0]
      o_overcurrent_threshold,
   output logic [lrocfg_pkg::NUM_CH*lrocfg_pkg::FS_W-1:0] o_full_scale,
   output logic [lrocfg_pkg::NUM_CH*lrocfg_pkg::STEP_W-1:0]
      o_threshold_step,
   output logic [lrocfg_pkg::NUM_CH-1:0] o_protect_enable,
   output logic [lrocfg_pkg::NUM_CH-1:0] o_overcurrent_error_flag,
   output logic [lrocfg_pkg::NUM_CH-1:0] o_channel_disable,
   output logic o_error_check_out_n
);
   import lrocfg_pkg::*;

   // =========================================================
   // configuration storage
   // =========================================================
   logic [NUM_CH-1:0] mode;
   logic [NUM_CH-1:0] rsel;
   logic [NUM_CH-1:0] sim;
   logic [CRNG_W-1:0] crng [NUM_CH];
   logic [DATA_W-1:0] thr [NUM_CH];
   logic [NUM_CH-1:0] flag;
   logic [NUM_CH-1:0] prot_en;
   logic [NUM_CH-1:0] det_s1;
   logic [NUM_CH-1:0] det_s2;
   logic [NUM_CH-1:0] det_s3;
   logic [NUM_CH-1:0] det_filt;
   logic [NUM_CH-1:0] lin_s1;
   logic [NUM_CH-1:0] lin_s2;
   logic [NUM_CH-1:0] lin_s3;
   logic [NUM_CH-1:0] lin_filt;
   logic [NUM_CH-1:0] next_flag;
   logic [DATA_W-1:0] next_rdata;

   // =========================================================
   // pin synchronisers: three stages, a change is taken only
   // once stages two and three agree, which also rejects a
   // single-cycle glitch from the comparator
   // =========================================================
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         det_s1 <= '0;
         det_s2 <= '0;
         det_s3 <= '0;
         lin_s1 <= '0;
         lin_s2 <= '0;
         lin_s3 <= '0;
      end else begin
         det_s1 <= i_overcurrent_detect;
         det_s2 <= det_s1;
         det_s3 <= det_s2;
         lin_s1 <= i_reference_linear_select;
         lin_s2 <= lin_s1;
         lin_s3 <= lin_s2;
      end
   end

   // filtered levels follow only when the last two stages match
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         det_filt <= '0;
         lin_filt <= '0;
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (det_s2[i] == det_s3[i]) begin
               det_filt[i] <= det_s3[i];
            end
            if (lin_s2[i] == lin_s3[i]) begin
               lin_filt[i] <= lin_s3[i];
            end
         end
      end
   end

   // =========================================================
   // per-channel registers and protection
   // =========================================================
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch

      // mode bit, each channel at its own offset
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            mode[c] <= MODE_POWER;
         end else if (i_reg_wr && i_reg_addr == MODE_ADDR[c]) begin
            mode[c] <= i_reg_wdata[MODE_BIT];
         end
      end

      // threshold code, FF after reset selects the maximum
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            thr[c] <= THR_RESET;
         end else if (i_reg_wr && i_reg_addr == THR_ADDR[c]) begin
            thr[c] <= i_reg_wdata;
         end
      end

      // range resistor bits share one register
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            rsel[c] <= RSEL_HIGH;
         end else if (i_reg_wr && i_reg_addr == RSEL_ADDR) begin
            rsel[c] <= i_reg_wdata[RSEL_BIT[c]];
         end
      end

      // fault simulation bits share one register
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            sim[c] <= 1'b0;
         end else if (i_reg_wr && i_reg_addr == SIM_ADDR) begin
            sim[c] <= i_reg_wdata[SIM_BIT[c]];
         end
      end

      // range codes share one register
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            crng[c] <= CRNG_RESET;
         end else if (i_reg_wr && i_reg_addr == CRNG_ADDR) begin
            crng[c] <= i_reg_wdata[CRNG_LSB[c] +: CRNG_W];
         end
      end

      // protection is off with a linear reference, or with code 00
      // in current regulation; in power regulation 00 is the minimum
      assign prot_en[c] = !lin_filt[c]
         && !(mode[c] == MODE_CURRENT && thr[c] == THR_OFF_CODE);

      // a simulated fault sets the flag every cycle it is held, so a
      // clear in the same cycle loses and the error stays forced
      assign next_flag[c] = sim[c]
         || (det_filt[c] && prot_en[c])
         || (flag[c] && !i_error_clear[c]);

      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            flag[c] <= 1'b0;
         end else begin
            flag[c] <= next_flag[c];
         end
      end

      // registered copies of settings for the analog side
      always_ff @(posedge i_clk or negedge i_rstn) begin
         if (!i_rstn) begin
            o_full_scale[c*FS_W +: FS_W] <= FS_HIGH[0];
            o_threshold_step[c*STEP_W +: STEP_W] <= STEP_HIGH_UA;
            o_current_range_factor[c*CRNG_W +: CRNG_W] <= CRNG_RESET;
            o_overcurrent_threshold[c*DATA_W +: DATA_W] <= THR_RESET;
         end else begin
            o_full_scale[c*FS_W +: FS_W] <= (rsel[c] == RSEL_HIGH) ?
               FS_HIGH[crng[c]] : FS_LOW[crng[c]];
            o_threshold_step[c*STEP_W +: STEP_W] <= (rsel[c] == RSEL_HIGH)
               ? STEP_HIGH_UA : STEP_LOW_UA;
            o_current_range_factor[c*CRNG_W +: CRNG_W] <= crng[c];
            o_overcurrent_threshold[c*DATA_W +: DATA_W] <= thr[c];
         end
      end
   end

   // =========================================================
   // status and control outputs, all registered
   // =========================================================
   // the check pin lags the flags by one cycle; it is a slow alarm
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_regulation_mode <= '0;
         o_range_resistor_select <= '0;
         o_protect_enable <= '0;
         o_overcurrent_error_flag <= '0;
         o_channel_disable <= '0;
         o_error_check_out_n <= 1'b1;
      end else begin
         o_regulation_mode <= mode;
         o_range_resistor_select <= rsel;
         o_protect_enable <= prot_en;
         o_overcurrent_error_flag <= flag;
         o_channel_disable <= flag;
         o_error_check_out_n <= !(|flag || i_other_error);
      end
   end

   // =========================================================
   // read back; unmapped offsets and unused bits read as zero
   // =========================================================
   always_comb begin
      next_rdata = '0;
      if (i_reg_addr == MODE_ADDR[0]) begin
         next_rdata[MODE_BIT] = mode[0];
      end else if (i_reg_addr == MODE_ADDR[1]) begin
         next_rdata[MODE_BIT] = mode[1];
      end else if (i_reg_addr == THR_ADDR[0]) begin
         next_rdata = thr[0];
      end else if (i_reg_addr == THR_ADDR[1]) begin
         next_rdata = thr[1];
      end else if (i_reg_addr == RSEL_ADDR) begin
         for (int i = 0; i < NUM_CH; i++) begin
            next_rdata[RSEL_BIT[i]] = rsel[i];
         end
      end else if (i_reg_addr == SIM_ADDR) begin
         for (int i = 0; i < NUM_CH; i++) begin
            next_rdata[SIM_BIT[i]] = sim[i];
         end
      end else if (i_reg_addr == CRNG_ADDR) begin
         for (int i = 0; i < NUM_CH; i++) begin
            next_rdata[CRNG_LSB[i] +: CRNG_W] = crng[i];
         end
      end
   end

   // read data is valid one cycle after the address
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata <= '0;
      end else begin
         o_reg_rdata <= next_rdata;
      end
   end

   // =========================================================
   // checks
   // =========================================================
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);

   a_sim_sets_flag: assert property (
      sim[0] |-> ##2 o_overcurrent_error_flag[0] && o_channel_disable[0])
      else $error("simulated fault did not raise flag");
   a_sim_holds_flag: assert property (
      sim[1] && i_error_clear[1] |=> flag[1])
      else $error("clear beat a held simulation");
   a_flag_to_check: assert property (
      flag[0] |=> !o_error_check_out_n)
      else $error("check output missed an error");
   a_check_idle_high: assert property (
      !(|flag) && !i_other_error |=> o_error_check_out_n)
      else $error("check output low without error");
   a_zero_code_off: assert property (
      mode[0] == MODE_CURRENT && thr[0] == THR_OFF_CODE
      |=> !o_protect_enable[0])
      else $error("code 00 left protection on");
   a_power_zero_on: assert property (
      mode[1] == MODE_POWER && !lin_filt[1] |=> o_protect_enable[1])
      else $error("power mode protection off");
   a_linear_off: assert property (
      lin_filt[0] |=> !o_protect_enable[0])
      else $error("linear reference left protection on");
   a_thr_write: assert property (
      i_reg_wr && i_reg_addr == THR_ADDR[1]
      |=> ##1 o_overcurrent_threshold[DATA_W +: DATA_W]
      == $past(i_reg_wdata, 2))
      else $error("threshold write not applied");
   a_sim_write: assert property (
      i_reg_wr && i_reg_addr == SIM_ADDR
      |=> sim[1] == $past(i_reg_wdata[SIM_BIT[1]]))
      else $error("simulation bit write wrong");
   a_step_select: assert property (
      rsel[0] != RSEL_HIGH |=> o_threshold_step[STEP_W-1:0] == STEP_LOW_UA)
      else $error("low range step wrong");
   a_range_low_scale: assert property (
      rsel[1] != RSEL_HIGH && crng[1] == 2'h3
      |=> o_full_scale[FS_W +: FS_W] == FS_LOW[3])
      else $error("low range full scale wrong");
   a_mode_readback: assert property (
      i_reg_wr && i_reg_addr == MODE_ADDR[0] ##1 i_reg_addr == MODE_ADDR[0]
      |=> o_reg_rdata[MODE_BIT] == $past(i_reg_wdata[MODE_BIT], 2))
      else $error("mode readback wrong");

endmodule : lrocfg_top

// ---- sim/lrocfg_host.sv ----
/*
 * Host microcontroller model: byte writes and reads on the register
 * port of the range and overcurrent block.
 * Assumes the device samples the port on the rising edge of i_clk.
 */
`timescale 1ns/1ps
module lrocfg_host (
   input wire logic i_clk,
   input wire logic [lrocfg_pkg::DATA_W-1:0] i_reg_rdata,
   output logic [lrocfg_pkg::ADDR_W-1:0] o_reg_addr,
   output logic [lrocfg_pkg::DATA_W-1:0] o_reg_wdata,
   output logic o_reg_wr
);
   // =========================================================
   // idle state
   // =========================================================
   // idle address is unmapped so a stale address reads as zero
   initial begin
      o_reg_addr = 8'hFF;
      o_reg_wdata = 8'h00;
      o_reg_wr = 1'b0;
   end

   // =========================================================
   // bus tasks
   // =========================================================
   // one byte write; data is inverted on release so nothing stale
   // can pass for a real value
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      o_reg_addr <= a;
      o_reg_wdata <= d;
      o_reg_wr <= 1'b1;
      @(posedge i_clk);
      o_reg_wr <= 1'b0;
      o_reg_wdata <= ~d;
   endtask : wr

   // read: address taken at one edge, data settled just after it
   // measure source setup is host business only, no port here
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_reg_addr <= a;
      @(posedge i_clk);
      #1 d = i_reg_rdata;
   endtask : rd
endmodule : lrocfg_host

// ---- sim/tb_top.sv ----
/*
 * Self-checking bench for the range and overcurrent configuration.
 * Assumes the host model in lrocfg_host and the package constants.
 */
`timescale 1ns/1ps
module tb_top;
   import lrocfg_pkg::*;
   logic i_clk, i_rstn, i_reg_wr, i_other_error;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, rv, t;
   logic [1:0] det, lin, clr, o_mode, o_rsel, o_pe, o_flag, o_dis;
   logic [1:0] c1, c2;
   logic r1, r2, m, e;
   logic [3:0] o_rng;
   logic [15:0] o_thr;
   logic [31:0] o_fs;
   logic [23:0] o_step;
   logic o_chk_n;
   integer fails, num_checks, seed, i, k;
   logic [7:0] ra [7] = '{8'h10, 8'h15, 8'h11, 8'h16, 8'h1A, 8'h1D, 8'h1E};
   logic [7:0] rm [7] = '{8'h01, 8'h01, 8'hFF, 8'hFF, 8'h11, 8'h60, 8'h33};
   logic [7:0] rr [7] = '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

   // =========================================================
   // clock and instances
   // =========================================================
   // 125 MHz
   initial i_clk = 1'b0;
   always #4 i_clk = ~i_clk;

   lrocfg_host host_u (.i_clk(i_clk), .i_reg_rdata(o_reg_rdata),
      .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata),
      .o_reg_wr(i_reg_wr));

   lrocfg_top dut_u (.i_clk(i_clk), .i_rstn(i_rstn),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
      .i_reg_wr(i_reg_wr), .i_overcurrent_detect(det),
      .i_reference_linear_select(lin), .i_error_clear(clr),
      .i_other_error(i_other_error), .o_reg_rdata(o_reg_rdata),
      .o_regulation_mode(o_mode), .o_range_resistor_select(o_rsel),
      .o_current_range_factor(o_rng), .o_overcurrent_threshold(o_thr),
      .o_full_scale(o_fs), .o_threshold_step(o_step),
      .o_protect_enable(o_pe), .o_overcurrent_error_flag(o_flag),
      .o_channel_disable(o_dis), .o_error_check_out_n(o_chk_n));

   // =========================================================
   // helpers
   // =========================================================
   // full scale in 0.1 mA units, low range when r is set
   function automatic logic [15:0] fs(input logic [1:0] c, input logic r);
      case ({r, c})
         3'h0: fs = 16'h1D4C;
         3'h1: fs = 16'h03E8;
         3'h2: fs = 16'h00FA;
         3'h3: fs = 16'h005A;
         3'h4: fs = 16'h0384;
         3'h5: fs = 16'h0078;
         3'h6: fs = 16'h001E;
         default: fs = 16'h000B;
      endcase
   endfunction : fs

   // threshold step in uA
   function automatic logic [11:0] step(input logic r);
      step = r ? 12'h177 : 12'hBB8;
   endfunction : step

   task chk(input string n, input logic [31:0] x, input logic [31:0] g);
      num_checks = num_checks + 1;
      if (g !== x) begin
         fails = fails + 1;
         $display("unexpected %s expected %h seen %h", n, x, g);
      end
   endtask : chk

   task rdchk(input string n, input logic [7:0] a, input logic [7:0] x);
      logic [7:0] d;
      host_u.rd(a, d);
      chk(n, {24'h0, x}, {24'h0, d});
   endtask : rdchk

   task idle(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask : idle

   // clear pulse is one cycle; the flag may only drop with no set cause
   task pulse_clr;
      @(posedge i_clk);
      clr <= 2'h3;
      @(posedge i_clk);
      clr <= 2'h0;
      idle(2);
   endtask : pulse_clr

   task end_of_test;
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : end_of_test

   // =========================================================
   // watchdog, far beyond the few hundred cycles needed
   // =========================================================
   initial begin
      #400000;
      fails = fails + 1;
      end_of_test;
   end

   // =========================================================
   // main sequence
   // =========================================================
   initial begin
      seed = 13;
      fails = 0;
      num_checks = 0;
      i_rstn = 1'b0;
      det = 2'h0;
      lin = 2'h0;
      clr = 2'h0;
      i_other_error = 1'b0;
      repeat (3) @(posedge i_clk);
      i_rstn <= 1'b1;
      idle(2);
      chk("check_n", 32'h1, {31'h0, o_chk_n});
      for (i = 0; i < 7; i++) begin
         rdchk("reset value", ra[i], rr[i]);
      end
      // random bytes, including the unmapped slot that must stay zero
      for (k = 0; k < 4; k++) begin
         for (i = 0; i < 7; i++) begin
            rv = 8'($random(seed));
            host_u.wr(ra[i], rv);
            rdchk("readback", ra[i], rv & rm[i]);
         end
         host_u.wr(8'h1F, rv);
         rdchk("unmapped", 8'h1F, 8'h00);
      end
      host_u.wr(8'h1D, 8'h00);
      pulse_clr;
      // every code against both range resistor settings
      for (i = 0; i < 16; i++) begin
         c1 = i[1:0];
         r1 = i[2];
         r2 = i[3];
         c2 = i[1:0] ^ i[3:2];
         host_u.wr(8'h1E, {2'h0, c2, 2'h0, c1});
         host_u.wr(8'h1A, {3'h0, r2, 3'h0, r1});
         idle(3);
         chk("full_scale", {fs(c2, r2), fs(c1, r1)}, o_fs);
         chk("step", {8'h0, step(r2), step(r1)}, {8'h0, o_step});
         chk("range", {28'h0, c2, c1}, {28'h0, o_rng});
         chk("rsel", {30'h0, r2, r1}, {30'h0, o_rsel});
      end
      // simulated overcurrent per channel, clear refused while set
      for (i = 0; i < 2; i++) begin
         host_u.wr(8'h1D, i ? 8'h40 : 8'h20);
         idle(3);
         chk("flag", 32'(1 << i), {30'h0, o_flag});
         chk("disable", 32'(1 << i), {30'h0, o_dis});
         chk("check_n", 32'h0, {31'h0, o_chk_n});
         pulse_clr;
         chk("flag held", 32'(1 << i), {30'h0, o_flag});
         host_u.wr(8'h1D, 8'h00);
         pulse_clr;
         chk("flag released", 32'h0, {30'h0, o_flag});
         chk("check_n", 32'h1, {31'h0, o_chk_n});
      end
      // mode, threshold code and linear reference against protection
      for (i = 0; i < 4; i++) begin
         m = (i == 0 || i == 2);
         rv = 8'($random(seed));
         t = (i < 2) ? 8'h00 : (rv | 8'h01);
         e = (i == 1 || i == 2);
         host_u.wr(8'h10, {7'h0, m});
         host_u.wr(8'h15, {7'h0, m});
         host_u.wr(8'h11, t);
         host_u.wr(8'h16, t);
         @(posedge i_clk);
         lin <= (i == 3) ? 2'h3 : 2'h0;
         // three stages, the filter edge, then the registered enable
         idle(5);
         chk("mode", {30'h0, m, m}, {30'h0, o_mode});
         chk("threshold", {16'h0, t, t}, {16'h0, o_thr});
         chk("protect", {30'h0, e, e}, {30'h0, o_pe});
         @(posedge i_clk);
         det <= 2'h3;
         idle(8);
         chk("detect flag", {30'h0, e, e}, {30'h0, o_flag});
         @(posedge i_clk);
         det <= 2'h0;
         idle(6);
         pulse_clr;
      end
      @(posedge i_clk);
      i_other_error <= 1'b1;
      idle(3);
      chk("check_n", 32'h0, {31'h0, o_chk_n});
      @(posedge i_clk);
      i_other_error <= 1'b0;
      idle(3);
      chk("check_n", 32'h1, {31'h0, o_chk_n});
      end_of_test;
   end
endmodule : tb_top
